// *** logic/cmt_pkg.sv ***
package cmt_pkg;

	// Register port widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] REG_UNIT_CHOICE = 8'h00;
	localparam logic [7:0] REG_UNIT_ON = 8'h04;
	localparam logic [7:0] REG_COEF_CHOICE = 8'h08;
	localparam logic [7:0] REG_COEF_VALUE = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;

	// Status field positions
	localparam int ST_FILL_LO = 0;
	localparam int ST_OUT_VALID = 2;
	localparam int ST_UNIT_ON_LO = 4;

	// Pixel and number formats: gains signed Q3.12, biases signed whole pixel steps
	localparam int COMP_W = 8;
	localparam int COEF_W = 16;
	localparam int FRAC = 12;
	localparam int PROD_W = COEF_W + COMP_W + 1;
	localparam int ACC_W = PROD_W + 3;
	localparam logic signed [COEF_W-1:0] GAIN_ONE = 16'sh1000;
	localparam logic signed [COEF_W-1:0] BIAS_ZERO = 16'sh0000;
	localparam logic signed [ACC_W-1:0] ROUND_HALF = 28'sh0000800;
	localparam logic signed [ACC_W-1:0] COMP_MAX = 28'sh00000FF;
	localparam logic signed [ACC_W-1:0] COMP_MIN = 28'sh0000000;

	// Transformation units
	localparam int NUM_UNITS = 2;
	localparam int UNIT_W = 1;
	typedef enum logic [UNIT_W-1:0] {
		colour_correct_unit = 1'h0,
		luma_chroma_convert_unit = 1'h1
	} cmt_unit_t;

	// Coefficient choice codes
	localparam int NUM_COEF = 12;
	localparam int CHOICE_W = 4;
	typedef enum logic [CHOICE_W-1:0] {
		coef_r0c0 = 4'h0, coef_r0c1 = 4'h1, coef_r0c2 = 4'h2,
		coef_r1c0 = 4'h3, coef_r1c1 = 4'h4, coef_r1c2 = 4'h5,
		coef_r2c0 = 4'h6, coef_r2c1 = 4'h7, coef_r2c2 = 4'h8,
		bias_first = 4'h9, bias_second = 4'hA, bias_third = 4'hB
	} cmt_coef_t;

	// Input buffer
	localparam int BUF_DEPTH = 2;
	localparam logic [1:0] BUF_FULL = 2'h2;

	// One colour pixel, first component in the low byte
	typedef struct packed {
		logic [COMP_W-1:0] c2;
		logic [COMP_W-1:0] c1;
		logic [COMP_W-1:0] c0;
	} cmt_pix_t;

endpackage : cmt_pkg

// *** logic/cmt_core.sv ***
`timescale 1ns/100ps
module cmt_core (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [cmt_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [cmt_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [cmt_pkg::DATA_W-1:0] reg_rdata,
	// Upstream pixels
	input wire logic in_valid,
	input wire cmt_pkg::cmt_pix_t in_pix,
	output logic in_ready,
	// Downstream pixels
	output logic out_valid,
	output cmt_pkg::cmt_pix_t out_pix,
	input wire logic out_ready
);

	// Local copies of the datapath widths, used as size casts below
	localparam int PROD_W = cmt_pkg::PROD_W;
	localparam int ACC_W = cmt_pkg::ACC_W;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Coefficient slot of a gain at row r, column c
	function automatic int gain_slot(input int r, input int c);
		gain_slot = r * 3 + c;
	endfunction : gain_slot

	// Round off the fraction and clamp to the component range
	function automatic logic [cmt_pkg::COMP_W-1:0] round_sat(
		input logic signed [cmt_pkg::ACC_W-1:0] acc);
		logic signed [cmt_pkg::ACC_W-1:0] r;
		r = (acc + cmt_pkg::ROUND_HALF) >>> cmt_pkg::FRAC;
		if (r > cmt_pkg::COMP_MAX)
			round_sat = cmt_pkg::COMP_MAX[cmt_pkg::COMP_W-1:0];
		else if (r < cmt_pkg::COMP_MIN)
			round_sat = cmt_pkg::COMP_MIN[cmt_pkg::COMP_W-1:0];
		else
			round_sat = r[cmt_pkg::COMP_W-1:0];
	endfunction : round_sat

	// Component k of a pixel
	function automatic logic [cmt_pkg::COMP_W-1:0] comp(input cmt_pkg::cmt_pix_t p,
		input int k);
		if (k == 0)
			comp = p.c0;
		else if (k == 1)
			comp = p.c1;
		else
			comp = p.c2;
	endfunction : comp

	////////////////////////////////////////////////////////////////////////////////
	// Settings

	cmt_pkg::cmt_unit_t unit_choice;
	cmt_pkg::cmt_coef_t coefficient_choice;
	logic [cmt_pkg::NUM_UNITS-1:0] transform_unit_on;
	logic signed [cmt_pkg::COEF_W-1:0] coef [cmt_pkg::NUM_UNITS][cmt_pkg::NUM_COEF];
	logic [1:0] buf_fill;
	logic choice_ok;
	logic unit_ok;

	assign choice_ok = 32'(coefficient_choice) < cmt_pkg::NUM_COEF;
	assign unit_ok = 32'(unit_choice) < cmt_pkg::NUM_UNITS;

	// Unit choice; with a single unit it would stay fixed at the first unit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			unit_choice <= cmt_pkg::colour_correct_unit;
		end else if (reg_wr && reg_addr == cmt_pkg::REG_UNIT_CHOICE
			&& cmt_pkg::NUM_UNITS > 1) begin
			unit_choice <= cmt_pkg::cmt_unit_t'(reg_wdata[cmt_pkg::UNIT_W-1:0]);
		end
	end

	// Per-unit enable, written through the chosen unit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			transform_unit_on <= '0;
		end else if (reg_wr && reg_addr == cmt_pkg::REG_UNIT_ON && unit_ok) begin
			transform_unit_on[unit_choice] <= reg_wdata[0];
		end
	end

	// Coefficient choice; codes past the last bias are kept but address nothing
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			coefficient_choice <= cmt_pkg::coef_r0c0;
		end else if (reg_wr && reg_addr == cmt_pkg::REG_COEF_CHOICE) begin
			coefficient_choice <= cmt_pkg::cmt_coef_t'(reg_wdata[cmt_pkg::CHOICE_W-1:0]);
		end
	end

	// Coefficient store; resets to identity so an enabled unit starts as a pass
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int u = 0; u < cmt_pkg::NUM_UNITS; u++) begin
				for (int k = 0; k < cmt_pkg::NUM_COEF; k++) begin
					coef[u][k] <= cmt_pkg::BIAS_ZERO;
				end
				for (int d = 0; d < 3; d++) begin
					coef[u][gain_slot(d, d)] <= cmt_pkg::GAIN_ONE;
				end
			end
		end else if (reg_wr && reg_addr == cmt_pkg::REG_COEF_VALUE && choice_ok && unit_ok) begin
			coef[unit_choice][coefficient_choice] <= reg_wdata[cmt_pkg::COEF_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read; data stands only in the cycle after the strobe

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (!reg_rd) begin
			reg_rdata <= '0;
		end else if (reg_addr == cmt_pkg::REG_UNIT_CHOICE) begin
			reg_rdata <= 32'(unit_choice);
		end else if (reg_addr == cmt_pkg::REG_UNIT_ON) begin
			reg_rdata <= unit_ok ? 32'(transform_unit_on[unit_choice]) : '0;
		end else if (reg_addr == cmt_pkg::REG_COEF_CHOICE) begin
			reg_rdata <= 32'(coefficient_choice);
		end else if (reg_addr == cmt_pkg::REG_COEF_VALUE) begin
			// Sign extended so software sees negative terms as such
			reg_rdata <= (choice_ok && unit_ok) ?
				32'(coef[unit_choice][coefficient_choice]) : '0;
		end else if (reg_addr == cmt_pkg::REG_STATUS) begin
			reg_rdata <= (32'(transform_unit_on) << cmt_pkg::ST_UNIT_ON_LO)
				| (32'(out_valid) << cmt_pkg::ST_OUT_VALID)
				| (32'(buf_fill) << cmt_pkg::ST_FILL_LO);
		end else begin
			reg_rdata <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Two-entry input buffer

	cmt_pkg::cmt_pix_t buf_mem [cmt_pkg::BUF_DEPTH];
	logic buf_wp;
	logic buf_rp;
	logic advance;
	logic push;
	logic pop;
	logic [1:0] next_fill;

	// The whole pipeline holds while the receiver stalls a waiting pixel
	assign advance = !out_valid || out_ready;
	assign push = in_valid && in_ready;
	assign pop = advance && buf_fill != 2'h0;
	assign next_fill = buf_fill + 2'(push) - 2'(pop);

	// Buffer storage and pointers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			buf_wp <= 1'b0;
			buf_rp <= 1'b0;
			buf_fill <= 2'h0;
		end else begin
			if (push) begin
				buf_mem[buf_wp] <= in_pix;
				buf_wp <= !buf_wp;
			end
			if (pop) begin
				buf_rp <= !buf_rp;
			end
			buf_fill <= next_fill;
		end
	end

	// Ready is registered, so it looks at the fill the buffer will have
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_ready <= 1'b0;
		end else begin
			in_ready <= next_fill != cmt_pkg::BUF_FULL;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transformation units in series, two stages each

	logic u_in_valid [cmt_pkg::NUM_UNITS];
	cmt_pkg::cmt_pix_t u_in_pix [cmt_pkg::NUM_UNITS];
	logic a_valid [cmt_pkg::NUM_UNITS];
	logic a_on [cmt_pkg::NUM_UNITS];
	cmt_pkg::cmt_pix_t a_pix [cmt_pkg::NUM_UNITS];
	logic signed [cmt_pkg::PROD_W-1:0] a_prod [cmt_pkg::NUM_UNITS][3][3];
	logic b_valid [cmt_pkg::NUM_UNITS];
	cmt_pkg::cmt_pix_t b_pix [cmt_pkg::NUM_UNITS];

	assign u_in_valid[0] = buf_fill != 2'h0;
	assign u_in_pix[0] = buf_mem[buf_rp];

	for (genvar u = 0; u < cmt_pkg::NUM_UNITS; u++) begin : g_unit
		if (u > 0) begin : g_chain
			assign u_in_valid[u] = b_valid[u-1];
			assign u_in_pix[u] = b_pix[u-1];
		end

		// Stage one: nine products, enable sampled with the pixel
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				a_valid[u] <= 1'b0;
				a_on[u] <= 1'b0;
			end else if (advance) begin
				a_valid[u] <= u_in_valid[u];
				a_on[u] <= transform_unit_on[u];
			end
		end

		// Products in signed fixed point; the pixel rides along for bypass
		always_ff @(posedge core_clk) begin
			if (advance) begin
				a_pix[u] <= u_in_pix[u];
				for (int r = 0; r < 3; r++) begin
					for (int c = 0; c < 3; c++) begin
						a_prod[u][r][c] <= PROD_W'(coef[u][gain_slot(r, c)]
							* $signed({1'b0, comp(u_in_pix[u], c)}));
					end
				end
			end
		end

		// Stage two valid
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				b_valid[u] <= 1'b0;
			end else if (advance) begin
				b_valid[u] <= a_valid[u];
			end
		end

		// Stage two: row sums plus bias, then round and clamp, or pass through
		always_ff @(posedge core_clk) begin
			if (advance) begin
				if (a_on[u]) begin
					b_pix[u].c0 <= round_sat(row_sum(u, 0));
					b_pix[u].c1 <= round_sat(row_sum(u, 1));
					b_pix[u].c2 <= round_sat(row_sum(u, 2));
				end else begin
					b_pix[u] <= a_pix[u];
				end
			end
		end
	end

	// Row r of unit u: dot product plus its bias scaled up to the product fraction.
	// Bias range covers the chroma midpoint; gains cover the signed chroma weights.
	function automatic logic signed [cmt_pkg::ACC_W-1:0] row_sum(input int u, input int r);
		logic signed [cmt_pkg::ACC_W-1:0] s;
		s = ACC_W'(coef[u][cmt_pkg::NUM_COEF - 3 + r]) <<< cmt_pkg::FRAC;
		for (int c = 0; c < 3; c++) begin
			s = s + ACC_W'(a_prod[u][r][c]);
		end
		row_sum = s;
	endfunction : row_sum

	////////////////////////////////////////////////////////////////////////////////
	// Output stage is a register after the last unit's second stage

	// Copied into dedicated output flops, kept in step with the pipeline
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_pix <= '0;
		end else if (advance) begin
			out_valid <= b_valid[cmt_pkg::NUM_UNITS-1];
			out_pix <= b_pix[cmt_pkg::NUM_UNITS-1];
		end
	end

endmodule : cmt_core

// *** test/cmt_props.sv ***
`timescale 1ns/100ps
module cmt_props (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [cmt_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [cmt_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [cmt_pkg::DATA_W-1:0] reg_rdata,
	// Pixel stream
	input wire logic in_valid,
	input wire cmt_pkg::cmt_pix_t in_pix,
	input wire logic in_ready,
	input wire logic out_valid,
	input wire cmt_pkg::cmt_pix_t out_pix,
	input wire logic out_ready
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	// One read request at a given offset
	sequence s_rd(a);
		reg_rd && reg_addr == a;
	endsequence
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
		else $error("read data not zero outside a read");
	a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_pix))
		else $error("output pixel lost under stall");
	a_unmapped_zero: assert property (reg_rd && reg_addr > cmt_pkg::REG_STATUS |=> reg_rdata == '0)
		else $error("unmapped read not zero");
	a_unit_field: assert property (s_rd(cmt_pkg::REG_UNIT_CHOICE) |=> reg_rdata[31:1] == '0)
		else $error("unit choice upper bits set");
	a_on_field: assert property (s_rd(cmt_pkg::REG_UNIT_ON) |=> reg_rdata[31:1] == '0)
		else $error("enable upper bits set");
	a_choice_field: assert property (s_rd(cmt_pkg::REG_COEF_CHOICE) |=> reg_rdata[31:4] == '0)
		else $error("coefficient choice upper bits set");
	a_value_sext: assert property (s_rd(cmt_pkg::REG_COEF_VALUE) |=> reg_rdata[31:16] == {16{reg_rdata[15]}})
		else $error("coefficient value not sign extended");
	a_status_valid: assert property (s_rd(cmt_pkg::REG_STATUS) |=> reg_rdata[2] == $past(out_valid) && reg_rdata[31:6] == '0)
		else $error("status does not follow output valid");
endmodule : cmt_props

// *** test/cmt_sink.sv ***
`timescale 1ns/100ps
module cmt_sink (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Pace, high makes this stage slow
	input wire logic slow,
	// Pixel stream
	output logic out_ready
);
	logic [1:0] cnt;
	// Slow mode takes one pixel in four, so the pipe backs up into the buffer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 2'h0;
			out_ready <= 1'b0;
		end else begin
			cnt <= cnt + 2'h1;
			out_ready <= !slow || cnt == 2'h3;
		end
	end
endmodule : cmt_sink

// *** test/color_matrix_transform_tb.sv ***
`timescale 1ns/100ps
module color_matrix_transform_tb;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic in_valid = 1'b0;
	cmt_pkg::cmt_pix_t in_pix = '0;
	logic in_ready, out_valid, out_ready;
	logic slow = 1'b0;
	logic refused = 1'b0;
	cmt_pkg::cmt_pix_t out_pix;
	cmt_pkg::cmt_pix_t rxq[$];
	cmt_pkg::cmt_pix_t ps[$];
	int miscompares = 0;
	int checked = 0;
	int gi[9] = '{4096, 0, 0, 0, 4096, 0, 0, 0, 4096};
	int gm[9] = '{0, 4096, 0, 8192, 0, 0, 2048, 2048, 0};
	int bm[3] = '{5, -10, 0};
	int gy[9] = '{1225, 2404, 467, -602, -1184, 1786, 2519, -2109, -410};
	int by[3] = '{0, 128, 128};
	always #4 core_clk = ~core_clk;
	cmt_core uut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.in_valid, .in_pix, .in_ready, .out_valid, .out_pix, .out_ready);
	cmt_sink sink (.core_clk, .rst_n, .slow, .out_ready);
	// Collect every pixel the downstream stage takes
	always @(posedge core_clk) if (out_valid === 1'b1 && out_ready === 1'b1) rxq.push_back(out_pix);
	////////////////////////////////////////
	task end_sim;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Data stand only in the cycle after the strobe
	task rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rchk
	task load(input logic u, input int g[9], input int b[3]);
		wr(cmt_pkg::REG_UNIT_CHOICE, u);
		for (int k = 0; k < 12; k++) begin
			wr(cmt_pkg::REG_COEF_CHOICE, k);
			wr(cmt_pkg::REG_COEF_VALUE, k < 9 ? g[k] : b[k - 9]);
		end
	endtask : load
	// Reference arithmetic, rounding half up then clamping
	function automatic cmt_pkg::cmt_pix_t calc(int g[9], int b[3], cmt_pkg::cmt_pix_t p);
		int s;
		cmt_pkg::cmt_pix_t r;
		for (int i = 0; i < 3; i++) begin
			s = b[i] * 4096 + 2048;
			for (int j = 0; j < 3; j++) s += g[i * 3 + j] * int'(p[j * 8 +: 8]);
			s = s >>> 12;
			r[i * 8 +: 8] = s < 0 ? 8'h00 : s > 255 ? 8'hFF : s[7:0];
		end
		return r;
	endfunction : calc
	// Holds valid across pixels so a busy buffer sees them back to back
	task send;
		int n;
		@(posedge core_clk);
		foreach (ps[i]) begin
			in_valid <= 1'b1;
			in_pix <= ps[i];
			for (n = 0; n < 100; n++) begin
				@(posedge core_clk);
				if (in_ready === 1'b1) break;
				refused = 1'b1;
			end
			if (n == 100) begin
				miscompares++;
				end_sim();
			end
		end
		in_valid <= 1'b0;
	endtask : send
	task getall(input int g[9], input int b[3]);
		int n;
		foreach (ps[i]) begin
			for (n = 0; n < 300 && rxq.size() == 0; n++) @(posedge core_clk);
			if (n == 300) begin
				miscompares++;
				end_sim();
			end
			chk({8'h00, rxq.pop_front()}, {8'h00, calc(g, b, ps[i])});
		end
	endtask : getall
	////////////////////////////////////////
	task t_regs;
		rchk(cmt_pkg::REG_UNIT_CHOICE, 32'h0);
		rchk(cmt_pkg::REG_UNIT_ON, 32'h0);
		for (int k = 0; k < 12; k++) begin
			wr(cmt_pkg::REG_COEF_CHOICE, k);
			rchk(cmt_pkg::REG_COEF_VALUE, k < 9 ? gi[k] : 0);
		end
		wr(cmt_pkg::REG_COEF_CHOICE, 32'hC);
		wr(cmt_pkg::REG_COEF_VALUE, 32'h5);
		rchk(cmt_pkg::REG_COEF_VALUE, 32'h0);
		rchk(8'h14, 32'h0);
	endtask : t_regs
	// Both units off, so pixels must come out untouched
	task t_pass;
		ps = '{24'h123456, 24'hFF00A5};
		send();
		getall(gi, '{0, 0, 0});
	endtask : t_pass
	// Swapped, doubled and averaged rows with biases; three outputs clamp
	task t_mat;
		load(1'b0, gm, bm);
		wr(cmt_pkg::REG_UNIT_ON, 32'h1);
		// Point back at the second bias, the only negative term loaded
		wr(cmt_pkg::REG_COEF_CHOICE, 32'hA);
		rchk(cmt_pkg::REG_COEF_VALUE, 32'hFFFFFFF6);
		ps = '{24'h102030, 24'h00FFF0, 24'h000003};
		send();
		getall(gm, bm);
	endtask : t_mat
	task t_yuv;
		wr(cmt_pkg::REG_UNIT_ON, 32'h0);
		load(1'b1, gy, by);
		wr(cmt_pkg::REG_UNIT_ON, 32'h1);
		rchk(cmt_pkg::REG_STATUS, 32'h20);
		rchk(cmt_pkg::REG_UNIT_CHOICE, 32'h1);
		ps = '{24'h3C80C8, 24'hFFFFFF, 24'h0000FF};
		send();
		getall(gy, by);
	endtask : t_yuv
	// A slow receiver must fill the buffer without losing a pixel
	task t_stall;
		slow <= 1'b1;
		ps = {};
		for (int i = 0; i < 14; i++) ps.push_back({8'(i * 20), 8'(255 - i * 9), 8'(i * 7)});
		send();
		getall(gy, by);
		chk(refused, 1'b1);
		slow <= 1'b0;
	endtask : t_stall
	initial begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		t_regs();
		t_pass();
		t_mat();
		t_yuv();
		t_stall();
		end_sim();
	end
endmodule : color_matrix_transform_tb
bind cmt_core cmt_props chk_i (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .in_valid, .in_pix, .in_ready, .out_valid, .out_pix, .out_ready);
